// ---- core/vga_general_params.svh ----
`ifndef VGA_GENERAL_PARAMS_SVH
`define VGA_GENERAL_PARAMS_SVH
// i/o port addresses
`define PORT_MISC_WR      16'h03C2
`define PORT_MISC_RD      16'h03CC
`define PORT_STATUS0_RD   16'h03C2
`define PORT_PIXEL_MASK   16'h03C6
`define PORT_INPUT_STATUS_ZERO_RD      16'h03CA
`define PORT_MONO_STATUS  16'h03BA
`define PORT_COLOR_STATUS 16'h03DA
`define PORT_MONO_INDEX   16'h03B4
`define PORT_MONO_DATA    16'h03B5
`define PORT_COLOR_INDEX  16'h03D4
`define PORT_COLOR_DATA   16'h03D5
// misc output fields
`define MISC_VSYNC_POL    7
`define MISC_HSYNC_POL    6
`define MISC_PAGE_SEL     5
`define MISC_CLK_SEL_HI   3
`define MISC_CLK_SEL_LO   2
`define MISC_MEM_EN       1
`define MISC_IO_COLOR     0
`define MISC_WR_MASK      8'hEF
// feature control fields
`define INPUT_STATUS_ZERO_VSYNC_OR     3
`define INPUT_STATUS_ZERO_WR_MASK      8'h08
// status fields
`define STAT0_IRQ         7
`define STAT0_SENSE       4
`define STAT1_DIAG_HI     5
`define STAT1_DIAG_LO     4
`define STAT1_VRETRACE    3
`define STAT1_BLANK       0
// reset values
`define MISC_RESET        8'h00
`define INPUT_STATUS_ZERO_RESET        8'h00
`define PIXEL_MASK_RESET  8'hFF
// overlay code of the overlay control field
`define OVERLAY_CODE      2'h3
`endif

// ---- core/vga_general_pkg.sv ----
`default_nettype none
package vga_general_pkg;
   typedef enum logic [1:0]
   {
      CLK_SYNTH_A = 2'h0,
      CLK_SYNTH_B = 2'h1,
      CLK_SYNTH_C = 2'h2,
      CLK_SYNTH_D = 2'h3
   } clock_select_t;
   typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ---- core/vga_general_registers.sv ----
// Operation
// RL1 - misc bit 7 inverts vertical sync: 0 rises at sync, 1 falls
// RL2 - misc bit 6 inverts horizontal sync: 0 rises at sync, 1 falls
// RL3 - in even/odd mode misc bit 5 picks address lsb: 0 odd, 1 even
// RL4 - page select ignored when graphics chain or chain-four enabled
// RL5 - strap high: clock select 00..11 picks synthesizer a..d
// RL6 - strap low: external clock; 1X to dac and counters, 0X dac only
// RL7 - misc bit 1 low blocks all host display-memory accesses
// RL8 - misc bit 0 picks mono 3B4/3B5/3BA or color 3D4/3D5/3DA ports
// RL9 - misc written at 3C2h, read back at 3CCh
// RL10 - feature control written at 3DAh, read back at 3CAh; with misc bit 0 low the code writes it at 3BAh instead
// RL11 - feature bit 3 ors display enable into vertical sync pin; resets 0
// RL12 - reads at 3C2h return input status zero, not misc
// RL13 - status zero bit 7 shows pending display interrupt
// RL14 - status zero bit 4 shows monitor-sense comparison
// RL15 - status one bits 5:4 mirror pixel pair chosen by plane-enable field
// RL16 - overlay configuration shows external pixel-bus inputs on diagnostic bits
// RL17 - status one bit 3 is high during vertical retrace
// RL18 - status one bit 0 is low when active, high in blanking
// RL19 - pixel mask zero bits clear matching pixel bits in lut index
// RL20 - reserved bits read zero; writes to them ignored
`timescale 1ns/100ps
`default_nettype none
`include "vga_general_params.svh"
module vga_general_registers
   import vga_general_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   // host i/o port
   input  wire logic [15:0] ioAddr,
   input  wire logic        ioWr,
   input  wire logic        ioRd,
   input  wire logic [7:0]  ioWrData,
   output var  logic [7:0]  ioRdData,
   output var  logic        ioRdHit,
   // host display-memory request
   input  wire logic        memReq,
   input  wire logic        memAddrLsb,
   output var  logic        memReqAccept,
   output var  logic        memAddrLsbOut,
   // mode inputs from other units
   input  wire logic        evenOddMode,
   input  wire logic        graphicsChain,
   input  wire logic        chainFourMode,
   input  wire logic [1:0]  colorPlaneDiag,
   input  wire logic [1:0]  overlaySelect,
   // timing unit
   input  wire logic        hsyncRaw,
   input  wire logic        vsyncRaw,
   input  wire logic        displayEnable,
   input  wire logic        verticalRetrace,
   input  wire logic        interruptPending,
   // pixel path
   input  wire logic [7:0]  attrPixel,
   input  wire logic [7:0]  pixelBusPin,
   output var  logic [7:0]  lutIndex,
   // pins and straps
   input  wire logic        monitorSensePin,
   input  wire logic        external_clock_strap_n,
   output var  logic        hsyncPin,
   output var  logic        vsyncPin,
   // clock routing
   output var  logic [1:0]  synthSelect,
   output var  logic        useExternalClock,
   output var  logic        externalClockToCounters,
   // port decode
   output var  logic        colorIoMode,
   output var  logic        timingIndexHit,
   output var  logic        timingDataHit
);
   byte_t misc_q;
   byte_t input_status_zero_q;
   byte_t mask_q;
   logic  senseS;
   logic  strapS;
   logic  overlayS0;
   logic [7:0] pixelBusS;
   logic  statusHit;
   logic  miscWr;
   logic  featWr;
   logic  maskWr;
   logic  overlayOn;
   logic [1:0] diagBits;
   byte_t status0;
   byte_t status1;
   byte_t rdData_d;
   logic  rdHit_d;
   logic  pageEffective;

   // pin synchronisers
   vga_pin_sync senseSync
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clkEn   (clkEn),
      .pinIn   (monitorSensePin),
      .pinOut  (senseS)
   );

   vga_pin_sync strapSync
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clkEn   (clkEn),
      .pinIn   (external_clock_strap_n),
      .pinOut  (strapS)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : gPix
         vga_pin_sync pixSync
         (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .clkEn   (clkEn),
            .pinIn   (pixelBusPin[gi]),
            .pinOut  (pixelBusS[gi])
         );
      end
   endgenerate

   // address decode
   always_comb
   begin
      statusHit = misc_q[`MISC_IO_COLOR] ? (ioAddr == `PORT_COLOR_STATUS)
                                         : (ioAddr == `PORT_MONO_STATUS); // RL8
      miscWr    = ioWr && (ioAddr == `PORT_MISC_WR); // RL9
      featWr    = ioWr && statusHit; // RL10
      maskWr    = ioWr && (ioAddr == `PORT_PIXEL_MASK);
   end

   // misc output register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         misc_q <= `MISC_RESET;
      else if (clkEn && miscWr)
         misc_q <= ioWrData & `MISC_WR_MASK; // RL20
   end

   // feature control register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         input_status_zero_q <= `INPUT_STATUS_ZERO_RESET; // RL11
      else if (clkEn && featWr)
         input_status_zero_q <= ioWrData & `INPUT_STATUS_ZERO_WR_MASK; // RL20
   end

   // pixel mask register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         mask_q <= `PIXEL_MASK_RESET;
      else if (clkEn && maskWr)
         mask_q <= ioWrData;
   end

   // status views
   always_comb
   begin
      overlayOn = (overlaySelect == `OVERLAY_CODE);
      unique case (colorPlaneDiag) // RL15
         2'h0: diagBits = overlayOn ? {pixelBusS[2], pixelBusS[0]} : {attrPixel[2], attrPixel[0]};
         2'h1: diagBits = overlayOn ? {pixelBusS[5], pixelBusS[4]} : {attrPixel[5], attrPixel[4]};
         2'h2: diagBits = overlayOn ? {pixelBusS[3], pixelBusS[1]} : {attrPixel[3], attrPixel[1]};
         2'h3: diagBits = overlayOn ? {pixelBusS[7], pixelBusS[6]} : {attrPixel[7], attrPixel[6]};
      endcase // RL16
      status0 = 8'h00; // RL20
      status0[`STAT0_IRQ]   = interruptPending; // RL13
      status0[`STAT0_SENSE] = senseS; // RL14
      status1 = 8'h00;
      status1[`STAT1_DIAG_HI:`STAT1_DIAG_LO] = diagBits;
      status1[`STAT1_VRETRACE] = verticalRetrace; // RL17
      status1[`STAT1_BLANK]    = ~displayEnable; // RL18
   end

   // read mux
   always_comb
   begin
      rdData_d = 8'h00;
      rdHit_d  = 1'b0;
      if (ioRd)
      begin
         rdHit_d = 1'b1;
         if (ioAddr == `PORT_STATUS0_RD)
            rdData_d = status0; // RL12
         else if (ioAddr == `PORT_MISC_RD)
            rdData_d = misc_q; // RL9
         else if (ioAddr == `PORT_INPUT_STATUS_ZERO_RD)
            rdData_d = input_status_zero_q; // RL10
         else if (ioAddr == `PORT_PIXEL_MASK)
            rdData_d = mask_q;
         else if (statusHit)
            rdData_d = status1;
         else
            rdHit_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ioRdData <= 8'h00;
         ioRdHit  <= 1'b0;
      end
      else if (clkEn)
      begin
         ioRdData <= rdData_d;
         ioRdHit  <= rdHit_d;
      end
   end

   // display memory gating
   always_comb
      pageEffective = evenOddMode && !graphicsChain && !chainFourMode; // RL4

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         memReqAccept  <= 1'b0;
         memAddrLsbOut <= 1'b0;
      end
      else if (clkEn)
      begin
         memReqAccept  <= memReq && misc_q[`MISC_MEM_EN]; // RL7
         memAddrLsbOut <= pageEffective ? ~misc_q[`MISC_PAGE_SEL] : memAddrLsb; // RL3
      end
   end

   // sync pins
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hsyncPin <= 1'b0;
         vsyncPin <= 1'b0;
      end
      else if (clkEn)
      begin
         hsyncPin <= hsyncRaw ^ misc_q[`MISC_HSYNC_POL]; // RL2
         vsyncPin <= (vsyncRaw | (input_status_zero_q[`INPUT_STATUS_ZERO_VSYNC_OR] & displayEnable))
                     ^ misc_q[`MISC_VSYNC_POL]; // RL1 RL11
      end
   end

   // pixel lookup index
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         lutIndex <= 8'h00;
      else if (clkEn)
         lutIndex <= attrPixel & mask_q; // RL19
   end

   // clock routing
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         synthSelect             <= CLK_SYNTH_A;
         useExternalClock        <= 1'b0;
         externalClockToCounters <= 1'b0;
      end
      else if (clkEn)
      begin
         synthSelect             <= misc_q[`MISC_CLK_SEL_HI:`MISC_CLK_SEL_LO]; // RL5
         useExternalClock        <= ~strapS; // RL6
         externalClockToCounters <= ~strapS & misc_q[`MISC_CLK_SEL_HI]; // RL6
      end
   end

   // port decode outputs
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         colorIoMode    <= 1'b0;
         timingIndexHit <= 1'b0;
         timingDataHit  <= 1'b0;
      end
      else if (clkEn)
      begin
         colorIoMode    <= misc_q[`MISC_IO_COLOR];
         timingIndexHit <= (ioWr || ioRd) && (misc_q[`MISC_IO_COLOR] ?
                           ioAddr == `PORT_COLOR_INDEX : ioAddr == `PORT_MONO_INDEX); // RL8
         timingDataHit  <= (ioWr || ioRd) && (misc_q[`MISC_IO_COLOR] ?
                           ioAddr == `PORT_COLOR_DATA : ioAddr == `PORT_MONO_DATA); // RL8
      end
   end
endmodule
`default_nettype wire

// ---- core/vga_pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// three-stage input synchroniser; change taken when stages two and three agree
module vga_pin_sync
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic clkEn,
   // pin
   input  wire logic pinIn,
   output var  logic pinOut
);
   logic s1Q;
   logic s2Q;
   logic s3Q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1Q    <= 1'b0;
         s2Q    <= 1'b0;
         s3Q    <= 1'b0;
         pinOut <= 1'b0;
      end
      else if (clkEn)
      begin
         s1Q <= pinIn;
         s2Q <= s1Q;
         s3Q <= s2Q;
         if (s2Q == s3Q)
            pinOut <= s3Q;
      end
   end
endmodule
`default_nettype wire

// ---- dv/vga_general_registers_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module vga_general_registers_sva
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        clkEn,
   // watched ports
   input wire logic [15:0] ioAddr,
   input wire logic        ioWr,
   input wire logic        ioRd,
   input wire logic [7:0]  ioWrData,
   input wire logic [7:0]  ioRdData,
   input wire logic        ioRdHit,
   input wire logic        memReq,
   input wire logic        memReqAccept,
   input wire logic [7:0]  attrPixel,
   input wire logic [7:0]  lutIndex
);
   logic [7:0]  misc_q, input_status_zero_q, mask_q;
   logic [15:0] statPort;
   logic        wr, rd;
   logic        memGate;
   logic [7:0]  lutExp;
   assign wr = clkEn && ioWr;
   assign rd = clkEn && ioRd;
   assign statPort = misc_q[0] ? 16'h03DA : 16'h03BA;
   assign memGate = memReq && misc_q[1];
   assign lutExp = attrPixel & mask_q;
   // shadow copies of writable registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         misc_q <= 8'h00;
         input_status_zero_q <= 8'h00;
         mask_q <= 8'hFF;
      end
      else if (wr && ioAddr == 16'h03C2)
         misc_q <= ioWrData & 8'hEF;
      else if (wr && ioAddr == statPort)
         input_status_zero_q <= ioWrData & 8'h08;
      else if (wr && ioAddr == 16'h03C6)
         mask_q <= ioWrData;
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   property p_misc;
      rd && ioAddr == 16'h03CC |=> ioRdHit && ioRdData == $past(misc_q);
   endproperty
   a_misc: assert property (p_misc) else $error("misc read");
   property p_input_status_zero;
      rd && ioAddr == 16'h03CA |=> ioRdHit && ioRdData == $past(input_status_zero_q);
   endproperty
   a_input_status_zero: assert property (p_input_status_zero) else $error("feature read");
   property p_mask;
      rd && ioAddr == 16'h03C6 |=> ioRdHit && ioRdData == $past(mask_q);
   endproperty
   a_mask: assert property (p_mask) else $error("mask read");
   property p_unmapped;
      rd && ioAddr == 16'h03C0 |=> !ioRdHit && ioRdData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_stat0;
      rd && ioAddr == 16'h03C2 |=> ioRdHit && (ioRdData & 8'h6F) == 8'h00;
   endproperty
   a_stat0: assert property (p_stat0) else $error("status zero");
   property p_stat1;
      rd && ioAddr == statPort |=> ioRdHit && (ioRdData & 8'hC6) == 8'h00;
   endproperty
   a_stat1: assert property (p_stat1) else $error("status one");
   property p_mem;
      clkEn |=> memReqAccept == $past(memGate);
   endproperty
   a_mem: assert property (p_mem) else $error("memory gate");
   property p_lut;
      clkEn ##1 clkEn |-> lutIndex == $past(lutExp);
   endproperty
   a_lut: assert property (p_lut) else $error("lut index");
endmodule
bind vga_general_registers vga_general_registers_sva u_vga_general_registers_sva
(
   .sys_clk, .rst_n, .clkEn, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData, .ioRdHit,
   .memReq, .memReqAccept, .attrPixel, .lutIndex
);
`default_nettype wire

// ---- dv/vga_general_registers_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module vga_general_registers_tb
   import vga_general_pkg::*;
;
   logic        sys_clk, rst_n, clkEn, ioWr, ioRd, ioRdHit, memReq, memAddrLsb, memReqAccept;
   logic        memAddrLsbOut, evenOddMode, graphicsChain, chainFourMode, hsyncRaw, vsyncRaw;
   logic        displayEnable, verticalRetrace, interruptPending, monitorSensePin, hsyncPin;
   logic        external_clock_strap_n, vsyncPin, useExternalClock, externalClockToCounters;
   logic        colorIoMode, timingIndexHit, timingDataHit, hit;
   logic [15:0] ioAddr;
   logic [1:0]  colorPlaneDiag, overlaySelect, synthSelect;
   byte_t       ioWrData, ioRdData, attrPixel, pixelBusPin, lutIndex, rd, px;
   int          bad_count = 0;
   int          checked = 0;
   int          hiBit [4] = '{2, 5, 3, 7};
   int          loBit [4] = '{0, 4, 1, 6};
   vga_general_registers u_vga_general_registers
   (
      .sys_clk, .rst_n, .clkEn, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData, .ioRdHit, .memReq,
      .memAddrLsb, .memReqAccept, .memAddrLsbOut, .evenOddMode, .graphicsChain, .chainFourMode,
      .colorPlaneDiag, .overlaySelect, .hsyncRaw, .vsyncRaw, .displayEnable, .verticalRetrace,
      .interruptPending, .attrPixel, .pixelBusPin, .lutIndex, .monitorSensePin,
      .external_clock_strap_n, .hsyncPin, .vsyncPin, .synthSelect, .useExternalClock,
      .externalClockToCounters, .colorIoMode, .timingIndexHit, .timingDataHit
   );
   vga_host_model u_vga_host_model
   (
      .sys_clk, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData, .ioRdHit
   );
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic io(input logic w, input logic [15:0] a, input byte_t d);
      u_vga_host_model.access(w, a, d, rd, hit);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial
   begin
      #100000;
      bad_count++;
      report_and_stop();
   end
   initial
   begin
      {rst_n, evenOddMode, graphicsChain, chainFourMode, hsyncRaw, vsyncRaw} = '0;
      {memAddrLsb, colorPlaneDiag, overlaySelect, verticalRetrace} = '0;
      {clkEn, memReq, displayEnable, interruptPending, monitorSensePin} = '1;
      external_clock_strap_n = 1'b1;
      attrPixel = 8'hA6;
      pixelBusPin = 8'h59;
      idle(8);
      rst_n = 1'b1;
      io(1'b0, 16'h03CA, 8'h00);
      io(1'b0, 16'h03C6, 8'h00);
      io(1'b0, 16'h03C0, 8'h00);
      io(1'b1, 16'h03C2, 8'hFF);
      io(1'b0, 16'h03CC, 8'h00);
      io(1'b0, 16'h03C2, 8'h00);
      chk("status0", rd, 8'h90);
      {interruptPending, monitorSensePin} = '0;
      idle(6);
      io(1'b0, 16'h03C2, 8'h00);
      chk("status0", rd, 8'h00);
      io(1'b1, 16'h03DA, 8'hFF);
      io(1'b0, 16'h03CA, 8'h00);
      chk("vsync", vsyncPin, 1'b0);
      chk("hsync", hsyncPin, 1'b1);
      displayEnable = 1'b0;
      idle(2);
      chk("vsync", vsyncPin, 1'b1);
      io(1'b1, 16'h03C2, 8'h00);
      io(1'b1, 16'h03DA, 8'h00);
      io(1'b0, 16'h03CA, 8'h00);
      chk("hsync", hsyncPin, 1'b0);
      chk("vsync", vsyncPin, 1'b0);
      chk("accept", memReqAccept, 1'b0);
      chk("color", colorIoMode, 1'b0);
      {hsyncRaw, vsyncRaw} = 2'b11;
      idle(2);
      chk("hsync", hsyncPin, 1'b1);
      chk("vsync", vsyncPin, 1'b1);
      {hsyncRaw, vsyncRaw} = 2'b00;
      $display("registers done");
      verticalRetrace = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         colorPlaneDiag = i[1:0];
         overlaySelect = {i[2], i[2]};
         px = i[2] ? pixelBusPin : attrPixel;
         idle(6);
         io(1'b0, 16'h03BA, 8'h00);
         chk("status1", rd, {2'b00, px[hiBit[i % 4]], px[loBit[i % 4]], 4'b1001});
      end
      {verticalRetrace, displayEnable, colorPlaneDiag, overlaySelect} = 6'b010000;
      idle(6);
      io(1'b0, 16'h03BA, 8'h00);
      chk("status1", rd, 8'h20);
      io(1'b1, 16'h03C6, 8'h5A);
      attrPixel = 8'hFF;
      evenOddMode = 1'b1;
      io(1'b1, 16'h03C2, 8'h02);
      idle(1);
      chk("odd", memAddrLsbOut, 1'b1);
      chk("lut", lutIndex, 8'h5A);
      chainFourMode = 1'b1;
      idle(2);
      chk("chain", memAddrLsbOut, 1'b0);
      {chainFourMode, graphicsChain} = 2'b01;
      idle(2);
      chk("chain", memAddrLsbOut, 1'b0);
      {chainFourMode, graphicsChain, memAddrLsb} = 3'b001;
      io(1'b1, 16'h03C2, 8'h22);
      idle(1);
      chk("even", memAddrLsbOut, 1'b0);
      chk("accept", memReqAccept, 1'b1);
      $display("status and memory done");
      for (int c = 0; c < 4; c++)
      begin
         io(1'b1, 16'h03C2, {4'h0, c[1:0], 2'b01});
         io(1'b1, 16'h03D4, 8'h00);
         chk("synth", synthSelect, c[1:0]);
         chk("index", timingIndexHit, 1'b1);
      end
      chk("color", colorIoMode, 1'b1);
      io(1'b1, 16'h03D5, 8'h00);
      chk("data", timingDataHit, 1'b1);
      io(1'b1, 16'h03B4, 8'h00);
      chk("index", timingIndexHit, 1'b0);
      chk("data", timingDataHit, 1'b0);
      chk("extClk", useExternalClock, 1'b0);
      external_clock_strap_n = 1'b0;
      idle(6);
      chk("extClk", useExternalClock, 1'b1);
      chk("counters", externalClockToCounters, 1'b1);
      io(1'b1, 16'h03C2, 8'h05);
      idle(1);
      chk("counters", externalClockToCounters, 1'b0);
      $display("clock and ports done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// ---- dv/vga_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module vga_host_model
(
   // clock
   input  wire logic        sys_clk,
   // host i/o port
   output var  logic [15:0] ioAddr,
   output var  logic        ioWr,
   output var  logic        ioRd,
   output var  logic [7:0]  ioWrData,
   input  wire logic [7:0]  ioRdData,
   input  wire logic        ioRdHit
);
   initial
   begin
      ioAddr = 16'hFFFF;
      ioWr = 1'b0;
      ioRd = 1'b0;
      ioWrData = 8'h00;
   end
   // one strobe cycle, then lines turn over
   task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic hit);
      @(negedge sys_clk);
      ioAddr = a;
      ioWrData = d;
      ioWr = w;
      ioRd = !w;
      @(negedge sys_clk);
      q = ioRdData;
      hit = ioRdHit;
      ioAddr = ~a;
      ioWrData = ~d;
      ioWr = 1'b0;
      ioRd = 1'b0;
   endtask
endmodule
`default_nettype wire
